// file: hw/pcc_clock_ctrl.sv
// Chosen here: the register addresses and the AXI4-Lite interface to the registers.
module pcc_clock_ctrl #(
  parameter int unsigned LOCK_CYC = pcc_pkg::LOCK_CYCLES
) (
  // clock, reset, enable
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        ce,
  // axi4-lite write
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // axi4-lite read
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // asynchronous pins
  input  wire logic        lp_osc_in,
  input  wire logic        prec_osc_in,
  input  wire logic        crystal_input_pin,
  input  wire logic        pll_lock_in,
  input  wire logic        pll_run_in,
  input  wire logic        wake_in,
  // clock control outputs
  output logic [1:0]       ref_sel,
  output logic             pll_ref_tick,
  output logic [9:0]       pll_fb_div,
  output logic             sys_fast,
  output logic             sys_tick,
  output logic             core_tick,
  output logic             core_run,
  output logic             power_down,
  output logic             adc_tick,
  output logic             wdt_tick
);
  import pcc_pkg::*;

  localparam int unsigned LW = $clog2(LOCK_CYC + 1);

  // returns 2^cd - 1 as the core counter limit
  function automatic logic [6:0] cd_limit(input logic [2:0] cd);
    cd_limit = 7'h7F >> (3'h7 - cd);
  endfunction

  // synchroniser: lp, prec, xtal, lock, run, wake
  logic [5:0] sync1, sync2, next_sync1, next_sync2;
  always_comb begin
    next_sync1 = {wake_in, pll_run_in, pll_lock_in, crystal_input_pin, prec_osc_in, lp_osc_in};
    next_sync2 = sync1;
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      sync1 <= '0;
      sync2 <= '0;
    end else if (ce) begin
      sync1 <= next_sync1;
      sync2 <= next_sync2;
    end
  end

  logic lock_s, run_s, wake_s, xtal_s;
  assign xtal_s = sync2[2];
  assign lock_s = sync2[3];
  assign run_s  = sync2[4];
  assign wake_s = sync2[5];

  // oscillator edge dividers
  pcc_tick_if lp4_if ();
  pcc_tick_if prec4_if ();
  pcc_tick_if lpraw_if ();
  pcc_tick_if xtal_if ();
  assign lp4_if.lvl   = sync2[0];
  assign prec4_if.lvl = sync2[1];
  assign lpraw_if.lvl = sync2[0];
  assign xtal_if.lvl  = xtal_s;

  pcc_edge_div #(.DIV(OSC_DIV)) u_lp4   (.clk(clk), .rst(rst), .ce(ce), .t(lp4_if));
  pcc_edge_div #(.DIV(OSC_DIV)) u_prec4 (.clk(clk), .rst(rst), .ce(ce), .t(prec4_if));
  pcc_edge_div #(.DIV(1))       u_lpraw (.clk(clk), .rst(rst), .ce(ce), .t(lpraw_if));
  pcc_edge_div #(.DIV(1))       u_xtal  (.clk(clk), .rst(rst), .ce(ce), .t(xtal_if));

  // bus and register state
  logic        aw_hold, w_hold, next_aw_hold, next_w_hold;
  logic [7:0]  waddr, next_waddr;
  logic [31:0] wdata, next_wdata;
  logic [3:0]  wstrb, next_wstrb;
  logic        next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
  logic [1:0]  next_bresp, next_rresp;
  logic [31:0] next_rdata;
  pcc_key_e    key, next_key;
  logic [1:0]  src, next_src, held_src, next_held_src;
  logic [2:0]  cd, next_cd;
  logic [3:0]  mode, next_mode;
  logic [6:0]  held_pow, next_held_pow;
  logic        irq, next_irq, adc_lp, next_adc_lp, tout, next_tout;
  logic        locked, next_locked, acq, next_acq, wake_prev;
  logic [LW-1:0] lock_cnt, next_lock_cnt;
  logic        wr_go, wake_rise, lock_fall;

  assign wr_go     = aw_hold && w_hold && !s_axi_bvalid;
  assign wake_rise = wake_s && !wake_prev;
  assign lock_fall = locked && !next_locked;

  // read data for one register word; key registers read zero
  function automatic logic [31:0] rd_word(input logic [7:0] a, input logic [1:0] s,
                                          input logic [2:0] c, input logic [3:0] m,
                                          input logic [2:0] st, input logic [1:0] ax);
    rd_word = 32'h0000_0000;
    case (a)
      OFF_STATE:   rd_word[2:0] = st;
      OFF_PLL_SRC: rd_word[SRC_LSB +: 2] = s;
      OFF_POW:     rd_word[6:0] = {m, c};
      OFF_AUX:     rd_word[1:0] = ax;
      default:     rd_word = 32'h0000_0000;
    endcase
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == OFF_STATE) || (a == OFF_POW_KEY0) || (a == OFF_POW) || (a == OFF_POW_KEY1) ||
             (a == OFF_PLL_KEY0) || (a == OFF_PLL_SRC) || (a == OFF_PLL_KEY1) || (a == OFF_AUX);
  endfunction

  // axi slave, key sequencer, registers; one write and one read at a time
  always_comb begin
    next_aw_hold  = aw_hold;
    next_w_hold   = w_hold;
    next_waddr    = waddr;
    next_wdata    = wdata;
    next_wstrb    = wstrb;
    next_bvalid   = s_axi_bvalid;
    next_bresp    = s_axi_bresp;
    next_rvalid   = s_axi_rvalid;
    next_rresp    = s_axi_rresp;
    next_rdata    = s_axi_rdata;
    next_key      = key;
    next_src      = src;
    next_held_src = held_src;
    next_cd       = cd;
    next_mode     = mode;
    next_held_pow = held_pow;
    next_irq      = irq;
    next_adc_lp   = adc_lp;
    next_tout     = tout;
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_hold = 1'b1;
      next_waddr   = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_hold = 1'b1;
      next_wdata  = s_axi_wdata;
      next_wstrb  = s_axi_wstrb;
    end
    if (s_axi_bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
    if (wr_go) begin
      next_aw_hold = 1'b0;
      next_w_hold  = 1'b0;
      next_bvalid  = 1'b1;
      next_bresp   = mapped(waddr) ? RESP_OKAY : RESP_SLVERR;
      next_key     = PCC_K_IDLE; // any write out of sequence breaks it
      case (waddr)
        OFF_PLL_KEY0: if (wdata == PLL_KEY0) next_key = PCC_K_PLL_ARM;
        OFF_PLL_SRC: begin
          if (key == PCC_K_PLL_ARM && wstrb[0]) begin
            next_held_src = wdata[SRC_LSB +: 2];
            next_key      = PCC_K_PLL_HELD;
          end
        end
        OFF_PLL_KEY1: if (key == PCC_K_PLL_HELD && wdata == PLL_KEY1) next_src = held_src;
        OFF_POW_KEY0: if (wdata == POW_KEY0) next_key = PCC_K_POW_ARM;
        OFF_POW: begin
          if (key == PCC_K_POW_ARM && wstrb[0]) begin
            next_held_pow = wdata[6:0];
            next_key      = PCC_K_POW_HELD;
          end
        end
        OFF_POW_KEY1: begin
          if (key == PCC_K_POW_HELD && wdata == POW_KEY1) begin
            next_cd   = held_pow[CD_LSB +: 3];
            next_mode = held_pow[MODE_LSB +: 4];
          end
        end
        OFF_STATE: if (wstrb[0] && wdata[ST_IRQ_BIT]) next_irq = 1'b0;
        OFF_AUX: begin
          if (wstrb[0]) begin
            next_adc_lp = wdata[AUX_ADCLP_BIT];
            if (wdata[AUX_TOUT_BIT]) next_tout = 1'b0;
          end
        end
        default: next_key = PCC_K_IDLE;
      endcase
    end
    // hardware sets win over software clears
    if (lock_fall) next_irq = 1'b1;
    if (acq && !lock_s && lock_cnt == LW'(LOCK_CYC - 1)) next_tout = 1'b1;
    // wake leaves power-down regardless of bus traffic
    if (wake_rise && mode != MODE_ACTIVE) next_mode = MODE_ACTIVE;
    if (s_axi_rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      next_rvalid = 1'b1;
      next_rresp  = mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      next_rdata  = rd_word(s_axi_araddr, src, cd, mode, {xtal_s, locked, irq}, {tout, adc_lp});
    end
    next_awready = !next_aw_hold && !next_bvalid;
    next_wready  = !next_w_hold && !next_bvalid;
    next_arready = !next_rvalid;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      aw_hold       <= 1'b0;
      w_hold        <= 1'b0;
      waddr         <= 8'h00;
      wdata         <= 32'h0000_0000;
      wstrb         <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rresp   <= RESP_OKAY;
      s_axi_rdata   <= 32'h0000_0000;
      key           <= PCC_K_IDLE;
      src           <= SRC_RST;
      held_src      <= SRC_RST;
      cd            <= CD_RST;
      mode          <= MODE_RST;
      held_pow      <= {MODE_RST, CD_RST};
      irq           <= 1'b0;
      adc_lp        <= 1'b0;
      tout          <= 1'b0;
    end else if (ce) begin
      aw_hold       <= next_aw_hold;
      w_hold        <= next_w_hold;
      waddr         <= next_waddr;
      wdata         <= next_wdata;
      wstrb         <= next_wstrb;
      s_axi_awready <= next_awready;
      s_axi_wready  <= next_wready;
      s_axi_bvalid  <= next_bvalid;
      s_axi_bresp   <= next_bresp;
      s_axi_arready <= next_arready;
      s_axi_rvalid  <= next_rvalid;
      s_axi_rresp   <= next_rresp;
      s_axi_rdata   <= next_rdata;
      key           <= next_key;
      src           <= next_src;
      held_src      <= next_held_src;
      cd            <= next_cd;
      mode          <= next_mode;
      held_pow      <= next_held_pow;
      irq           <= next_irq;
      adc_lp        <= next_adc_lp;
      tout          <= next_tout;
    end
  end

  // lock tracking and derived clock enables
  logic [2:0] sys_cnt, next_sys_cnt;
  logic [6:0] core_cnt, next_core_cnt;
  logic [5:0] adc_cnt, next_adc_cnt;
  logic       sys_c, adc_fast, ref_c;
  logic       next_core_tick, next_adc_tick, next_core_run, next_pd;

  always_comb begin
    next_acq      = acq;
    next_lock_cnt = lock_cnt;
    if (acq) begin
      if (lock_s || lock_cnt == LW'(LOCK_CYC - 1)) begin
        next_acq = 1'b0;
      end else begin
        next_lock_cnt = lock_cnt + LW'(1);
      end
    end
    next_locked = !acq && lock_s;
    // losing lock or waking restarts acquisition at the slow rate
    if ((locked && !lock_s) || (wake_rise && mode != MODE_ACTIVE)) begin
      next_acq      = 1'b1;
      next_lock_cnt = '0;
    end
    // slow system clock while unlocked, full rate once locked
    next_sys_cnt = locked ? 3'h0 : sys_cnt + 3'h1;
    sys_c        = locked || (sys_cnt == 3'(SYS_ACQ_DIV - 1));
    // core divider follows cd live; >= handles a shrinking limit
    next_core_cnt  = core_cnt;
    next_core_tick = 1'b0;
    if (sys_c) begin
      if (core_cnt >= cd_limit(cd)) begin
        next_core_cnt  = 7'h00;
        next_core_tick = core_run;
      end else begin
        next_core_cnt = core_cnt + 7'h01;
      end
    end
    // fixed adc divide from the pll rate
    next_adc_cnt = adc_cnt;
    adc_fast     = 1'b0;
    if (sys_c) begin
      if (adc_cnt == 6'(ADC_DIV - 1)) begin
        next_adc_cnt = 6'h00;
        adc_fast     = 1'b1;
      end else begin
        next_adc_cnt = adc_cnt + 6'h01;
      end
    end
    next_adc_tick = adc_lp ? lpraw_if.tick : adc_fast;
    // reference mux; reserved code gives no reference
    case (src)
      SRC_LP:   ref_c = lp4_if.tick;
      SRC_PREC: ref_c = prec4_if.tick;
      SRC_XTAL: ref_c = xtal_if.tick;
      default:  ref_c = 1'b0;
    endcase
    next_pd       = (next_mode != MODE_ACTIVE);
    next_core_run = run_s && !next_pd; // no wait for lock
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      acq          <= 1'b1;
      lock_cnt     <= '0;
      locked       <= 1'b0;
      wake_prev    <= 1'b0;
      sys_cnt      <= 3'h0;
      core_cnt     <= 7'h00;
      adc_cnt      <= 6'h00;
      sys_tick     <= 1'b0;
      sys_fast     <= 1'b0;
      core_tick    <= 1'b0;
      adc_tick     <= 1'b0;
      pll_ref_tick <= 1'b0;
      wdt_tick     <= 1'b0;
      ref_sel      <= SRC_RST;
      pll_fb_div   <= PLL_MULT;
      core_run     <= 1'b0;
      power_down   <= 1'b0;
    end else if (ce) begin
      acq          <= next_acq;
      lock_cnt     <= next_lock_cnt;
      locked       <= next_locked;
      wake_prev    <= wake_s;
      sys_cnt      <= next_sys_cnt;
      core_cnt     <= next_core_cnt;
      adc_cnt      <= next_adc_cnt;
      sys_tick     <= sys_c;
      sys_fast     <= locked;
      core_tick    <= next_core_tick;
      adc_tick     <= next_adc_tick;
      pll_ref_tick <= ref_c;
      wdt_tick     <= lp4_if.tick; // always running, no disable bit
      ref_sel      <= src;
      pll_fb_div   <= PLL_MULT;
      core_run     <= next_core_run;
      power_down   <= next_pd;
    end
  end

  // sample only on enabled edges so $past spans a frozen stretch
  default clocking cb @(posedge clk iff ce); endclocking
  default disable iff (rst || !ce);

  chk_slow_sys: assert property (!locked && sys_tick ##1 (!locked && !sys_tick)[*7] |=> sys_tick)
    else $error("sys tick not divided by eight while unlocked");
  chk_fast_sys: assert property ($past(locked) |-> sys_tick)
    else $error("sys tick missing while locked");
  chk_irq_fall: assert property ($fell(locked) |-> irq)
    else $error("lock loss did not set flag");
  chk_src_keyed: assert property ($changed(src) |-> $past(wr_go && waddr == OFF_PLL_KEY1 &&
                                  key == PCC_K_PLL_HELD && wdata == PLL_KEY1))
    else $error("source changed without key sequence");
  chk_cd_keyed: assert property ($changed(cd) |-> $past(wr_go && waddr == OFF_POW_KEY1 &&
                                 key == PCC_K_POW_HELD && wdata == POW_KEY1))
    else $error("core divide changed without key sequence");
  chk_reset_vals: assert property ($past(rst) |-> src == SRC_LP && cd == CD_RST)
    else $error("reset values wrong");
  chk_wdt_src: assert property (wdt_tick |-> $past(lp4_if.tick))
    else $error("watchdog tick not from lp oscillator");
  chk_adc_src: assert property (adc_tick |-> $past(adc_lp ? lpraw_if.tick : adc_fast))
    else $error("adc tick from wrong source");
  chk_core_run: assert property (core_run |-> $past(run_s && !next_pd))
    else $error("core running without pll oscillation");
  chk_lock_time: assert property (acq |-> lock_cnt <= LW'(LOCK_CYC - 1))
    else $error("lock wait exceeded bound");

  cov_lock_loss: cover property ($fell(locked));
  cov_src_commit: cover property ($changed(src));
  cov_wake: cover property (wake_rise && power_down);
  cov_adc_lp: cover property (adc_lp && adc_tick);

endmodule // pcc_clock_ctrl

// file: hw/pcc_pkg.sv
package pcc_pkg;

  // clock rates and timing
  localparam int unsigned CLK_HZ        = 20_000_000;
  localparam int unsigned PLL_HZ        = 20_480_000;
  localparam int unsigned ADC_HZ        = 512_000;
  localparam int unsigned LOCK_MAX_US   = 2000;
  localparam int unsigned LOCK_CYCLES   = LOCK_MAX_US * (CLK_HZ / 1_000_000);
  localparam int unsigned ADC_DIV       = PLL_HZ / ADC_HZ;
  localparam int unsigned OSC_DIV       = 4;
  localparam int unsigned SYS_ACQ_DIV   = 8;
  localparam logic [9:0]  PLL_MULT      = 10'h271;

  // register byte offsets
  localparam logic [7:0]  OFF_STATE     = 8'h00;
  localparam logic [7:0]  OFF_POW_KEY0  = 8'h04;
  localparam logic [7:0]  OFF_POW       = 8'h08;
  localparam logic [7:0]  OFF_POW_KEY1  = 8'h0C;
  localparam logic [7:0]  OFF_PLL_KEY0  = 8'h10;
  localparam logic [7:0]  OFF_PLL_SRC   = 8'h14;
  localparam logic [7:0]  OFF_PLL_KEY1  = 8'h18;
  localparam logic [7:0]  OFF_AUX       = 8'h1C;

  // key values
  localparam logic [31:0] PLL_KEY0      = 32'h0000_00AA;
  localparam logic [31:0] PLL_KEY1      = 32'h0000_0055;
  localparam logic [31:0] POW_KEY0      = 32'h0000_0001;
  localparam logic [31:0] POW_KEY1      = 32'h0000_00F4;

  // field positions
  localparam int unsigned SRC_LSB       = 0;
  localparam int unsigned CD_LSB        = 0;
  localparam int unsigned MODE_LSB      = 3;
  localparam int unsigned ST_IRQ_BIT    = 0;
  localparam int unsigned ST_LOCK_BIT   = 1;
  localparam int unsigned ST_XTAL_BIT   = 2;
  localparam int unsigned AUX_ADCLP_BIT = 0;
  localparam int unsigned AUX_TOUT_BIT  = 1;

  // source codes and reset values
  localparam logic [1:0]  SRC_LP        = 2'h0;
  localparam logic [1:0]  SRC_PREC      = 2'h1;
  localparam logic [1:0]  SRC_XTAL      = 2'h2;
  localparam logic [1:0]  SRC_RST       = SRC_LP;
  localparam logic [2:0]  CD_RST        = 3'h1;
  localparam logic [3:0]  MODE_ACTIVE   = 4'h7;
  localparam logic [3:0]  MODE_RST      = MODE_ACTIVE;

  // bus responses
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;

  typedef enum logic [2:0] {
    PCC_K_IDLE,
    PCC_K_PLL_ARM,
    PCC_K_PLL_HELD,
    PCC_K_POW_ARM,
    PCC_K_POW_HELD
  } pcc_key_e;

endpackage : pcc_pkg

// file: hw/pcc_tick_if.sv
interface pcc_tick_if;
  logic lvl;
  logic tick;
  modport div  (input lvl, output tick);
  modport user (output lvl, input tick);
endinterface : pcc_tick_if

// file: hw/pcc_edge_div.sv
module pcc_edge_div #(
  parameter int unsigned DIV = 4
) (
  // clock and control
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // level in, tick out
  pcc_tick_if.div  t
);
  import pcc_pkg::*;

  localparam int unsigned CW = (DIV > 1) ? $clog2(DIV) : 1;

  logic          prev;
  logic [CW-1:0] cnt;
  logic          tick_q;
  logic          next_prev;
  logic [CW-1:0] next_cnt;
  logic          next_tick;

  // count rising edges, one tick every DIV edges
  always_comb begin
    next_prev = t.lvl;
    next_cnt  = cnt;
    next_tick = 1'b0;
    if (t.lvl && !prev) begin
      if (cnt >= CW'(DIV - 1)) begin // >= also covers DIV of one
        next_cnt  = '0;
        next_tick = 1'b1;
      end else begin
        next_cnt = cnt + CW'(1);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      prev   <= 1'b0;
      cnt    <= '0;
      tick_q <= 1'b0;
    end else if (ce) begin
      prev   <= next_prev;
      cnt    <= next_cnt;
      tick_q <= next_tick;
    end
  end

  assign t.tick = tick_q;

endmodule // pcc_edge_div

// file: dv/tb_pcc_clock_ctrl.sv
module tb_pcc_clock_ctrl;
  timeunit 1ns;
  timeprecision 1ns;
  import pcc_pkg::*;

  localparam int unsigned LOCK_SIM = 50;

  // bench signals, named as the ports
  logic        clk, rst, ce;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, ref_sel;
  logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic        lp_osc_in, prec_osc_in, crystal_input_pin, pll_lock_in, pll_run_in, wake_in;
  logic        pll_ref_tick, sys_fast, sys_tick, core_tick, core_run, power_down, adc_tick, wdt_tick;
  logic [9:0]  pll_fb_div;
  int          err_count, n_tests, seed;
  int          n_core, n_sys, n_adc, n_wdt, n_ref;
  int          dc, ds, da, dw, dr;
  logic [31:0] d;
  logic [1:0]  r;
  logic [2:0]  cd;
  logic [1:0]  codes [4];

  pcc_clock_ctrl #(.LOCK_CYC(LOCK_SIM)) pcc_clock_ctrl_i (
    .clk, .rst, .ce,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready,
    .lp_osc_in, .prec_osc_in, .crystal_input_pin, .pll_lock_in, .pll_run_in, .wake_in,
    .ref_sel, .pll_ref_tick, .pll_fb_div, .sys_fast, .sys_tick, .core_tick, .core_run,
    .power_down, .adc_tick, .wdt_tick
  );

  // 20 MHz clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // lp period 16 cycles, prec period 8, so a swapped reference mux shows up
  always begin
    repeat (4) @(posedge clk);
    prec_osc_in <= ~prec_osc_in;
    repeat (4) @(posedge clk);
    lp_osc_in   <= ~lp_osc_in;
    prec_osc_in <= ~prec_osc_in;
  end

  // tick tallies; case equality keeps unknowns out of the counts
  always @(posedge clk) begin
    if (core_tick === 1'b1) n_core++;
    if (sys_tick === 1'b1) n_sys++;
    if (adc_tick === 1'b1) n_adc++;
    if (wdt_tick === 1'b1) n_wdt++;
    if (pll_ref_tick === 1'b1) n_ref++;
  end

  task automatic give_verdict;
    if (err_count == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask

  // tick counts over a window are allowed one off for phase
  function automatic logic [31:0] near(input int got, input int exp);
    return {31'h0, (got >= exp - 1) && (got <= exp + 1)};
  endfunction

  // reference ticks per 256 cycles; the crystal pin sits still here
  function automatic int ref_exp(input logic [1:0] c);
    return (c == SRC_PREC) ? 8 : (c == SRC_LP) ? 4 : 0;
  endfunction

  function automatic logic [31:0] pow_word(input logic [2:0] c, input logic [3:0] m);
    return {25'h0, m, c};
  endfunction

  task automatic hang;
    err_count++;
    give_verdict();
  endtask

  // one write; address and data offered together, each dropped when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    int i;
    @(posedge clk);
    s_axi_awaddr  <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata   <= v;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    for (i = 0; i < 100; i++) begin
      @(posedge clk);
      if (s_axi_awready === 1'b1 && s_axi_awvalid) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1 && s_axi_wvalid) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1) break;
    end
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
    if (i == 100) hang();
  endtask

  task automatic rd(input logic [7:0] a);
    int i;
    @(posedge clk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    for (i = 0; i < 100; i++) begin
      @(posedge clk);
      if (s_axi_arready === 1'b1 && s_axi_arvalid) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1) break;
    end
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    if (i == 100) hang();
  endtask

  task automatic keyed(input logic [7:0] ka, input logic [31:0] k0, input logic [7:0] ra,
                       input logic [31:0] v, input logic [31:0] k1);
    wr(ka, k0);
    wr(ra, v);
    wr(ka + 8'h08, k1);
    @(posedge clk); // one idle cycle after the bracket
  endtask

  task automatic span(input int n);
    int c0, s0, a0, w0, r0;
    c0 = n_core; s0 = n_sys; a0 = n_adc; w0 = n_wdt; r0 = n_ref;
    repeat (n) @(posedge clk);
    dc = n_core - c0; ds = n_sys - s0; da = n_adc - a0; dw = n_wdt - w0; dr = n_ref - r0;
  endtask

  // main sequence
  initial begin
    seed = 21367;
    {ce, pll_run_in, rst} = 3'b111;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = {16'h0000, 32'h0, 4'hF};
    {lp_osc_in, prec_osc_in, crystal_input_pin, pll_lock_in, wake_in} = 5'h00;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
    check("fb_div", pll_fb_div, 32'h0000_0271);
    check("ref_sel", ref_sel, SRC_LP);
    rd(OFF_POW);
    check("pow_rst", d, pow_word(CD_RST, MODE_RST));
    rd(8'h40);
    check("rresp_unmapped", r, RESP_SLVERR);
    wr(8'h40, 32'h0);
    check("bresp_unmapped", r, RESP_SLVERR);
    // every source code, reserved one too, then back to the low power oscillator
    codes = '{SRC_PREC, SRC_XTAL, 2'h3, SRC_LP};
    foreach (codes[i]) begin
      keyed(OFF_PLL_KEY0, PLL_KEY0, OFF_PLL_SRC, {30'h0, codes[i]}, PLL_KEY1);
      rd(OFF_PLL_SRC);
      check("src", d, {30'h0, codes[i]});
      check("ref_sel_code", ref_sel, codes[i]);
      span(256);
      check("ref_code", near(dr, ref_exp(codes[i])), 1);
    end
    // wrong post key, then a stray write inside the bracket
    keyed(OFF_PLL_KEY0, PLL_KEY0, OFF_PLL_SRC, 32'h2, 32'h56);
    wr(OFF_PLL_KEY0, PLL_KEY0);
    wr(8'h40, 32'h0);
    keyed(OFF_PLL_SRC, 32'h2, OFF_PLL_KEY1, PLL_KEY1, 32'h0);
    rd(OFF_PLL_SRC);
    check("src_kept", d, {30'h0, SRC_LP});
    pll_lock_in <= 1'b1;
    repeat (10) @(posedge clk);
    check("sys_fast", sys_fast, 1'b1);
    rd(OFF_STATE);
    check("lock_bit", d[ST_LOCK_BIT], 1'b1);
    // corner divides first, then random ones
    for (int i = 0; i < 4; i++) begin
      cd = (i == 0) ? 3'h0 : (i == 1) ? 3'h7 : 3'($random(seed));
      keyed(OFF_POW_KEY0, POW_KEY0, OFF_POW, pow_word(cd, MODE_ACTIVE), POW_KEY1);
      rd(OFF_POW);
      check("pow", d, pow_word(cd, MODE_ACTIVE));
      span(1024);
      check("core_rate", near(dc, 1024 >> cd), 1);
      check("sys_locked", near(ds, 1024), 1);
      check("adc_rate", near(da, 1024 / ADC_DIV), 1);
      check("wdt_rate", near(dw, 1024 / 64), 1);
      check("ref_rate", near(dr, 1024 / 64), 1);
    end
    wr(OFF_AUX, 32'h1);
    span(1024);
    check("adc_lp_rate", near(da, 1024 / 16), 1);
    wr(OFF_AUX, 32'h2); // low power off, timeout flag cleared
    // lock loss raises the flag; writing one clears it
    pll_lock_in <= 1'b0;
    repeat (6) @(posedge clk);
    rd(OFF_STATE);
    check("irq_lock", d[1:0], 2'b01);
    span(800);
    check("sys_acq", near(ds, 800 / SYS_ACQ_DIV), 1);
    rd(OFF_AUX);
    check("lock_tout", d, 32'h0000_0002);
    // clock enable low freezes every flop, the tick outputs too
    ce <= 1'b0;
    @(posedge clk);
    d = {31'h0, sys_tick};
    span(64);
    check("ce_hold", near(ds, d[0] ? 64 : 0), 1);
    ce <= 1'b1;
    wr(OFF_STATE, 32'h1);
    rd(OFF_STATE);
    check("irq_clr", d[ST_IRQ_BIT], 1'b0);
    for (int i = 0; i < 4; i++) begin
      crystal_input_pin <= 1'($random(seed));
      repeat (4) @(posedge clk);
      rd(OFF_STATE);
      check("crystal", d[ST_XTAL_BIT], crystal_input_pin);
    end
    // power down, then wake on the pin
    keyed(OFF_POW_KEY0, POW_KEY0, OFF_POW, pow_word(3'h1, 4'h0), POW_KEY1); // lp reference kept
    repeat (4) @(posedge clk);
    check("pd", {power_down, core_run}, 2'b10);
    span(256);
    check("wdt_in_pd", near(dw, 4), 1);
    wake_in <= 1'b1;
    repeat (8) @(posedge clk);
    check("wake", {power_down, core_run, sys_fast}, 3'b010);
    rd(OFF_POW);
    check("wake_mode", d, pow_word(3'h1, MODE_ACTIVE));
    // software polls the lock bit once the pll settles
    pll_lock_in <= 1'b1;
    d = 32'h0;
    for (int i = 0; i < 20 && d[ST_LOCK_BIT] !== 1'b1; i++) rd(OFF_STATE);
    check("relock", d[ST_LOCK_BIT], 1'b1);
    wake_in <= 1'b0;
    give_verdict();
  end
endmodule // tb_pcc_clock_ctrl
